// ==== logic/dtm_pkg.sv ====
`default_nettype none
package dtm_pkg;
    localparam int ADDR_W      = 32;
    localparam int DATA_W      = 64;
    localparam int CHANNELS    = 2;
    localparam int QUEUE_DEPTH = 4;
    localparam int QPTR_W      = 2;
    localparam int QCNT_W      = 3;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ACTION = 8'h04;
    localparam logic [7:0] REG_START0 = 8'h08;
    localparam logic [7:0] REG_END0   = 8'h0C;
    localparam logic [7:0] REG_START1 = 8'h10;
    localparam logic [7:0] REG_END1   = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    // control word fields
    localparam int CTRL_TM_LSB     = 0;
    localparam int CTRL_TM_DATA    = 1;
    localparam int CTRL_EVTI_SYNC  = 2;
    // action word fields
    localparam int ACT_RW0_LSB     = 30;
    localparam int ACT_RW1_LSB     = 28;
    localparam int ACT_WATCH0      = 0;
    localparam int ACT_WATCH1      = 1;
    // status word fields
    localparam int STAT_SYNC       = 0;
    localparam int STAT_OVERRUN    = 1;
    localparam int STAT_QCNT_LSB   = 2;
    localparam int STAT_STATE_LSB  = 5;
    localparam int STAT_CNT_LSB    = 8;

    localparam logic [1:0]  TM_RESET     = 2'h0;
    localparam logic        EVTI_RESET   = 1'b0;
    localparam logic [1:0]  RW_RESET     = 2'h0;
    localparam logic        WATCH_RESET  = 1'b0;
    localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

    // message type codes
    localparam logic [5:0] TC_WRITE      = 6'h05;
    localparam logic [5:0] TC_READ       = 6'h06;
    localparam logic [5:0] TC_ERROR      = 6'h08;
    localparam logic [5:0] TC_WRITE_SYNC = 6'h0D;
    localparam logic [5:0] TC_READ_SYNC  = 6'h0E;
    localparam logic [5:0] TC_WATCH      = 6'h0F;
    localparam logic [4:0] ECODE_OVERRUN = 5'h02;

    // access size codes
    localparam logic [1:0] SZ_BYTE  = 2'h0;
    localparam logic [1:0] SZ_HALF  = 2'h1;
    localparam logic [1:0] SZ_WORD  = 2'h2;
    localparam logic [1:0] SZ_DWORD = 2'h3;

    localparam logic [8:0] NONSYNC_LIMIT = 9'h100;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_TRACE = 2'b01,
        ST_WATCH = 2'b11
    } tx_state_t;
endpackage
`default_nettype wire

// ==== logic/data_trace_message_unit.sv ====
// Notes on behaviour
// - watch every data access, trace loads and stores
// - sync carries full address, else xor-compressed
// - data field as wide as access
// - trace only while trace mode bit one set
// - watchpoint triggers set/clear trace mode bit
// - two channels, each with start/end pair
// - hits perform that channel's selected actions
// - equal start/end matches single location only
// - watch enable bit emits watchpoint message
// - trace and watchpoint together on one channel
// - store gives write message, type five
// - write sync message type thirteen, full address
// - load gives read message, type six
// - first trace after reset uses sync
// - enabling trace forces next sync
// - power-down exit forces next sync
// - event-in with sync select forces sync
// - overrun: error message before next sync
// - at most 256 non-sync between syncs
// - debug-mode exit forces next sync
// - sync loads use read sync, type fourteen
// - window inclusive; start above end never matches
// - rw field: low bit reads, high bit writes
`timescale 1ns/1ns
`default_nettype none
module data_trace_message_unit
    import dtm_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        acc_valid_in,
    input  wire logic        acc_write_in,
    input  wire logic [31:0] acc_addr_in,
    input  wire logic [1:0]  acc_size_in,
    input  wire logic [63:0] acc_data_in,
    input  wire logic        power_down_exit_in,
    input  wire logic        debug_exit_in,
    input  wire logic        event_in_in,
    input  wire logic        watch_start_in,
    input  wire logic        watch_stop_in,
    input  wire logic        msg_ready_in,
    output logic             msg_valid_out,
    output logic      [5:0]  msg_tcode_out,
    output logic      [63:0] msg_data_out,
    output logic      [31:0] msg_addr_out,
    output logic      [1:0]  msg_size_out,
    output logic      [4:0]  msg_ecode_out,
    output logic      [1:0]  msg_watch_out
);

    function automatic logic [63:0] size_mask(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: size_mask = 64'h0000_0000_0000_00FF;
            SZ_HALF: size_mask = 64'h0000_0000_0000_FFFF;
            SZ_WORD: size_mask = 64'h0000_0000_FFFF_FFFF;
            default: size_mask = 64'hFFFF_FFFF_FFFF_FFFF;
        endcase
    endfunction

    logic [1:0]  tm;
    logic        evti_sel;
    logic [1:0]  rw_sel    [CHANNELS];
    logic [1:0]  watch_en;
    logic [31:0] chan_start [CHANNELS];
    logic [31:0] chan_end   [CHANNELS];
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        addr_phase;
    logic [31:0] rd_word;
    logic        tm_prev;
    logic        evt_prev;
    logic        sync_pending;
    logic        overrun;
    logic [8:0]  nonsync_cnt;
    logic [QCNT_W-1:0] q_count;
    logic [31:0] prev_addr;
    tx_state_t   state;
    tx_state_t   next_state;

    // ---------------- register bus slave ----------------
    assign addr_phase = hsel_in & htrans_in[1] & hready_in;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase & hwrite_in;
            wr_addr <= haddr_in[7:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= 32'h0000_0000;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= (addr_phase & ~hwrite_in) ? rd_word : 32'h0000_0000;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr_in[7:0])
            REG_CTRL: begin
                rd_word[CTRL_TM_LSB +: 2]  = tm;
                rd_word[CTRL_EVTI_SYNC]    = evti_sel;
            end
            REG_ACTION: begin
                rd_word[ACT_RW0_LSB +: 2]  = rw_sel[0];
                rd_word[ACT_RW1_LSB +: 2]  = rw_sel[1];
                rd_word[ACT_WATCH0]        = watch_en[0];
                rd_word[ACT_WATCH1]        = watch_en[1];
            end
            REG_START0: rd_word = chan_start[0];
            REG_END0:   rd_word = chan_end[0];
            REG_START1: rd_word = chan_start[1];
            REG_END1:   rd_word = chan_end[1];
            REG_STATUS: begin
                rd_word[STAT_SYNC]            = sync_pending;
                rd_word[STAT_OVERRUN]         = overrun;
                rd_word[STAT_QCNT_LSB +: 3]   = q_count;
                rd_word[STAT_STATE_LSB +: 2]  = state;
                rd_word[STAT_CNT_LSB +: 9]    = nonsync_cnt;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // trace mode: watchpoint triggers override a software write
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tm       <= TM_RESET;
            evti_sel <= EVTI_RESET;
        end else begin
            if (wr_pend && wr_addr == REG_CTRL) begin
                tm       <= hwdata_in[CTRL_TM_LSB +: 2];
                evti_sel <= hwdata_in[CTRL_EVTI_SYNC];
            end
            if (watch_start_in) begin
                tm[CTRL_TM_DATA] <= 1'b1;
            end else if (watch_stop_in) begin
                tm[CTRL_TM_DATA] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rw_sel[0] <= RW_RESET;
            rw_sel[1] <= RW_RESET;
            watch_en  <= {WATCH_RESET, WATCH_RESET};
        end else if (wr_pend && wr_addr == REG_ACTION) begin
            rw_sel[0]   <= hwdata_in[ACT_RW0_LSB +: 2];
            rw_sel[1]   <= hwdata_in[ACT_RW1_LSB +: 2];
            watch_en[0] <= hwdata_in[ACT_WATCH0];
            watch_en[1] <= hwdata_in[ACT_WATCH1];
        end
    end

    // ---------------- address channels ----------------
    logic [1:0] in_range;
    logic [1:0] trace_hit;
    logic [1:0] watch_hit;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        localparam logic [7:0] START_OFS = REG_START0 + 8'(8 * ch);
        localparam logic [7:0] END_OFS   = REG_END0 + 8'(8 * ch);

        always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                chan_start[ch] <= ADDR_RESET;
                chan_end[ch]   <= ADDR_RESET;
            end else begin
                if (wr_pend && wr_addr == START_OFS) begin
                    chan_start[ch] <= hwdata_in;
                end
                if (wr_pend && wr_addr == END_OFS) begin
                    chan_end[ch] <= hwdata_in;
                end
            end
        end

        // inclusive compare; start above end can never hold
        assign in_range[ch]  = (chan_start[ch] <= acc_addr_in) && (acc_addr_in <= chan_end[ch]);
        assign trace_hit[ch] = in_range[ch] & (acc_write_in ? rw_sel[ch][1] : rw_sel[ch][0]);
        assign watch_hit[ch] = in_range[ch] & watch_en[ch];
    end

    // ---------------- occurrence queue ----------------
    logic              push_trace;
    logic [1:0]        push_watch;
    logic              push;
    logic              accept;
    logic              drop;
    logic              pop;
    logic              q_full;
    logic              q_empty;
    logic [QPTR_W-1:0] wr_ptr;
    logic [QPTR_W-1:0] rd_ptr;
    logic              q_write [QUEUE_DEPTH];
    logic [31:0]       q_addr  [QUEUE_DEPTH];
    logic [63:0]       q_data  [QUEUE_DEPTH];
    logic [1:0]        q_size  [QUEUE_DEPTH];
    logic              q_trace [QUEUE_DEPTH];
    logic [1:0]        q_watch [QUEUE_DEPTH];

    assign push_trace = acc_valid_in & tm[CTRL_TM_DATA] & (|trace_hit);
    assign push_watch = acc_valid_in ? watch_hit : 2'b00;
    assign push       = push_trace | (|push_watch);
    assign q_full     = (q_count == QCNT_W'(QUEUE_DEPTH));
    assign q_empty    = (q_count == '0);
    assign accept     = push & (~q_full | pop);
    assign drop       = push & q_full & ~pop;

    always_ff @(posedge ref_clk_in) begin
        if (accept) begin
            q_write[wr_ptr] <= acc_write_in;
            q_addr[wr_ptr]  <= acc_addr_in;
            q_data[wr_ptr]  <= acc_data_in & size_mask(acc_size_in);
            q_size[wr_ptr]  <= acc_size_in;
            q_trace[wr_ptr] <= push_trace;
            q_watch[wr_ptr] <= push_watch;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            q_count <= '0;
        end else begin
            if (accept) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            q_count <= q_count + QCNT_W'(accept) - QCNT_W'(pop);
        end
    end

    // ---------------- sync and overrun flags ----------------
    logic tm_rise;
    logic evt_rise;
    logic need_sync;
    logic issue_err;
    logic issue_trace;
    logic issue_watch;
    logic out_free;

    assign tm_rise   = tm[CTRL_TM_DATA] & ~tm_prev;
    assign evt_rise  = event_in_in & ~evt_prev & evti_sel;
    assign need_sync = sync_pending | (nonsync_cnt >= NONSYNC_LIMIT);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tm_prev  <= 1'b0;
            evt_prev <= 1'b0;
        end else begin
            tm_prev  <= tm[CTRL_TM_DATA];
            evt_prev <= event_in_in;
        end
    end

    // pending sync: set wins over the clear of a sync send
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_pending <= 1'b1;
        end else if (tm_rise || power_down_exit_in || evt_rise || debug_exit_in || drop) begin
            sync_pending <= 1'b1;
        end else if (issue_trace && !overrun) begin
            // a drop after the error keeps sync owed to the next error
            sync_pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overrun <= 1'b0;
        end else if (drop) begin
            overrun <= 1'b1;
        end else if (issue_err) begin
            overrun <= 1'b0;
        end
    end

    // ---------------- message sequencer ----------------
    logic        head_write;
    logic [31:0] head_addr;
    logic        head_trace;
    logic [1:0]  head_watch;

    assign head_write = q_write[rd_ptr];
    assign head_addr  = q_addr[rd_ptr];
    assign head_trace = q_trace[rd_ptr];
    assign head_watch = q_watch[rd_ptr];
    assign out_free   = ~msg_valid_out | msg_ready_in;

    always_comb begin
        issue_err   = 1'b0;
        issue_trace = 1'b0;
        issue_watch = 1'b0;
        pop         = 1'b0;
        next_state  = state;
        if (out_free && !q_empty) begin
            case (state)
                ST_IDLE: begin
                    if (head_trace && overrun) begin
                        issue_err  = 1'b1;
                        next_state = ST_TRACE;
                    end else if (head_trace) begin
                        issue_trace = 1'b1;
                        if (|head_watch) begin
                            next_state = ST_WATCH;
                        end else begin
                            pop = 1'b1;
                        end
                    end else begin
                        issue_watch = 1'b1;
                        pop         = 1'b1;
                    end
                end
                ST_TRACE: begin
                    issue_trace = 1'b1;
                    if (|head_watch) begin
                        next_state = ST_WATCH;
                    end else begin
                        pop        = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
                ST_WATCH: begin
                    issue_watch = 1'b1;
                    pop         = 1'b1;
                    next_state  = ST_IDLE;
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_addr   <= ADDR_RESET;
            nonsync_cnt <= 9'h000;
        end else if (issue_trace) begin
            prev_addr <= head_addr;
            if (need_sync) begin
                nonsync_cnt <= 9'h000;
            end else begin
                nonsync_cnt <= nonsync_cnt + 9'h001;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            msg_valid_out <= 1'b0;
            msg_tcode_out <= 6'h00;
            msg_data_out  <= 64'h0;
            msg_addr_out  <= 32'h0;
            msg_size_out  <= 2'h0;
            msg_ecode_out <= 5'h00;
            msg_watch_out <= 2'h0;
        end else if (issue_err) begin
            msg_valid_out <= 1'b1;
            msg_tcode_out <= TC_ERROR;
            msg_ecode_out <= ECODE_OVERRUN;
            msg_data_out  <= 64'h0;
            msg_addr_out  <= 32'h0;
            msg_size_out  <= 2'h0;
            msg_watch_out <= 2'h0;
        end else if (issue_trace) begin
            msg_valid_out <= 1'b1;
            if (head_write) begin
                msg_tcode_out <= need_sync ? TC_WRITE_SYNC : TC_WRITE;
            end else begin
                msg_tcode_out <= need_sync ? TC_READ_SYNC : TC_READ;
            end
            msg_addr_out  <= need_sync ? head_addr : (head_addr ^ prev_addr);
            msg_data_out  <= q_data[rd_ptr];
            msg_size_out  <= q_size[rd_ptr];
            msg_ecode_out <= 5'h00;
            msg_watch_out <= 2'h0;
        end else if (issue_watch) begin
            msg_valid_out <= 1'b1;
            msg_tcode_out <= TC_WATCH;
            msg_addr_out  <= head_addr;
            msg_data_out  <= 64'h0;
            msg_size_out  <= q_size[rd_ptr];
            msg_ecode_out <= 5'h00;
            msg_watch_out <= head_watch;
        end else if (msg_ready_in) begin
            msg_valid_out <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_trace_needs_mode;
        push_trace |-> tm[CTRL_TM_DATA];
    endproperty
    a_trace_needs_mode: assert property (p_trace_needs_mode) else $error("trace queued with mode off");

    property p_write_plain;
        issue_trace && head_write && !need_sync |=> msg_valid_out && msg_tcode_out == TC_WRITE;
    endproperty
    a_write_plain: assert property (p_write_plain) else $error("write message code wrong");

    property p_write_sync;
        logic [31:0] a;
        (issue_trace && head_write && need_sync, a = head_addr) |=>
            msg_tcode_out == TC_WRITE_SYNC && msg_addr_out == a;
    endproperty
    a_write_sync: assert property (p_write_sync) else $error("write sync message wrong");

    property p_read_codes;
        issue_trace && !head_write |=> msg_tcode_out == ($past(need_sync) ? TC_READ_SYNC : TC_READ);
    endproperty
    a_read_codes: assert property (p_read_codes) else $error("read message code wrong");

    property p_err_then_sync;
        issue_err |=> msg_tcode_out == TC_ERROR && state == ST_TRACE && sync_pending;
    endproperty
    a_err_then_sync: assert property (p_err_then_sync) else $error("error not followed by sync");

    property p_count_bound;
        nonsync_cnt <= NONSYNC_LIMIT;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("non-sync count past limit");

    property p_prev_addr;
        logic [31:0] a;
        (issue_trace, a = head_addr) |=> prev_addr == a && (!$past(need_sync) || nonsync_cnt == 9'h000);
    endproperty
    a_prev_addr: assert property (p_prev_addr) else $error("reference address not updated");

    property p_drop_overrun;
        drop |=> overrun && sync_pending;
    endproperty
    a_drop_overrun: assert property (p_drop_overrun) else $error("drop not flagged");

    property p_window;
        in_range[0] |-> chan_start[0] <= chan_end[0];
    endproperty
    a_window: assert property (p_window) else $error("empty window matched");

    property p_byte_width;
        msg_valid_out && msg_tcode_out != TC_WATCH && msg_size_out == SZ_BYTE |-> msg_data_out[63:8] == 56'h0;
    endproperty
    a_byte_width: assert property (p_byte_width) else $error("byte data too wide");

    property p_hold;
        msg_valid_out && !msg_ready_in |=> msg_valid_out && $stable(msg_tcode_out) && $stable(msg_addr_out);
    endproperty
    a_hold: assert property (p_hold) else $error("message changed before taken");

    property p_hw_mode;
        watch_start_in |=> tm[CTRL_TM_DATA] ##1 (tm_prev || watch_stop_in);
    endproperty
    a_hw_mode: assert property (p_hw_mode) else $error("trace mode not set by trigger");

    c_write_sync: cover property (issue_trace && head_write && need_sync);
    c_error_msg:  cover property (issue_err ##1 issue_trace);
    c_both_kinds: cover property (issue_trace && |head_watch ##[1:20] issue_watch);
    c_drop:       cover property (drop);

endmodule // data_trace_message_unit
`default_nettype wire

// ==== testbench/trace_tool_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module trace_tool_model (
    input  wire logic        clk_in,
    input  wire logic        stall_in,
    input  wire logic        valid_in,
    input  wire logic [5:0]  tcode_in,
    input  wire logic [1:0]  size_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [63:0] data_in,
    input  wire logic [4:0]  ecode_in,
    input  wire logic [1:0]  watch_in,
    output logic             ready_out
);
    logic [110:0] got[$];
    logic         ph = 1'b0;
    initial ready_out = 1'b0;
    // slow receiver: takes a message every other cycle, none while stalled
    always @(posedge clk_in) begin
        if (valid_in && ready_out)
            got.push_back({watch_in, ecode_in, tcode_in, size_in, addr_in, data_in});
        ph <= ~ph;
        ready_out <= !stall_in && ph;
    end
endmodule // trace_tool_model
`default_nettype wire

// ==== testbench/data_trace_message_unit_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, e); end end
module data_trace_message_unit_test;
    import dtm_pkg::*;
    localparam logic [63:0] DV = 64'h1122_3344_5566_7788;
    logic        ref_clk_in, rst_n_in, hsel, hwr, hrdy, hresp, av, aw, stall, mrdy, mv;
    logic [4:0]  pv;
    logic [1:0]  htr, asz, msz, mw;
    logic [31:0] haddr, hwd, hrd, aa, ma, rd;
    logic [63:0] ad, md;
    logic [5:0]  mtc;
    logic [4:0]  mec;
    int          n_fail = 0;
    int          n_compared = 0;
    data_trace_message_unit i_dut (.ref_clk_in, .rst_n_in, .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htr),
        .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(hrdy), .hrdata_out(hrd), .hreadyout_out(hrdy),
        .hresp_out(hresp), .acc_valid_in(av), .acc_write_in(aw), .acc_addr_in(aa), .acc_size_in(asz),
        .acc_data_in(ad), .power_down_exit_in(pv[0]), .debug_exit_in(pv[1]), .event_in_in(pv[4]),
        .watch_start_in(pv[2]), .watch_stop_in(pv[3]), .msg_ready_in(mrdy), .msg_valid_out(mv),
        .msg_tcode_out(mtc), .msg_data_out(md), .msg_addr_out(ma), .msg_size_out(msz), .msg_ecode_out(mec),
        .msg_watch_out(mw));
    trace_tool_model i_tool (.clk_in(ref_clk_in), .stall_in(stall), .valid_in(mv), .tcode_in(mtc),
        .size_in(msz), .addr_in(ma), .data_in(md), .ecode_in(mec), .watch_in(mw), .ready_out(mrdy));
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #5000000;
        n_fail++;
        end_of_test;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htr <= 2'h2;
        hwr <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk_in); while (hrdy !== 1'b1);
        htr <= 2'h0;
        hwd <= d;
        do @(posedge ref_clk_in); while (hrdy !== 1'b1);
        rd = hrd;
        `CHK(hresp, 1'b0)
    endtask
    task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] s, input int n);
        for (int i = 0; i < n; i++) begin
            av <= 1'b1; aw <= w; aa <= a + 32'(4 * i); asz <= s; ad <= DV;
            @(posedge ref_clk_in);
        end
        av <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic pulse(input int k);
        pv[k] <= 1'b1;
        @(posedge ref_clk_in);
        pv[k] <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic expect_msg(input logic [5:0] tc, input logic [1:0] sz, input logic [31:0] a);
        logic [110:0] m;
        logic [63:0]  d;
        logic [1:0]   w;
        d = (sz == SZ_DWORD) ? DV : DV & ((64'h1 << (8 << sz)) - 64'h1);
        w = 2'b00;
        // only channel 0 watches in these scenarios
        if (tc == TC_WATCH) begin
            d = '0;
            w = 2'b01;
        end
        for (int t = 0; t < 100 && i_tool.got.size() == 0; t++) @(posedge ref_clk_in);
        m = (i_tool.got.size() > 0) ? i_tool.got.pop_front() : '1;
        `CHK(m, {w, 5'h00, tc, sz, a, d})
    endtask
    task automatic quiet;
        repeat (10) @(posedge ref_clk_in);
        `CHK(i_tool.got.size(), 0)
    endtask
    task automatic t_regs;
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[STAT_SYNC], 1'b1)
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK(rd[1:0], TM_RESET)
        bus(1'b1, REG_START0, 32'h100);
        bus(1'b1, REG_END0, 32'h1FF);
        bus(1'b0, REG_END0, 32'h0);
        `CHK(rd, 32'h1FF)
        bus(1'b0, 8'h1C, 32'h0);
        `CHK(rd, 32'h0)
        $display("t_regs done");
    endtask
    task automatic t_trace;
        bus(1'b1, REG_START1, 32'h300);
        bus(1'b1, REG_END1, 32'h300);
        bus(1'b1, REG_ACTION, 32'hD000_0000);
        bus(1'b1, REG_CTRL, 32'h2);
        acc(1'b1, 32'h100, SZ_WORD, 1);
        expect_msg(TC_WRITE_SYNC, SZ_WORD, 32'h100);
        acc(1'b0, 32'h1FF, SZ_BYTE, 1);
        expect_msg(TC_READ, SZ_BYTE, 32'h0FF);
        acc(1'b0, 32'h300, SZ_HALF, 1);
        expect_msg(TC_READ, SZ_HALF, 32'h2FF);
        acc(1'b1, 32'h100, SZ_DWORD, 1);
        expect_msg(TC_WRITE, SZ_DWORD, 32'h200);
        acc(1'b1, 32'h300, SZ_WORD, 1);
        acc(1'b0, 32'h304, SZ_WORD, 1);
        acc(1'b1, 32'h200, SZ_WORD, 1);
        quiet;
        $display("t_trace done");
    endtask
    task automatic t_sync;
        pulse(1);
        acc(1'b1, 32'h104, SZ_WORD, 1);
        expect_msg(TC_WRITE_SYNC, SZ_WORD, 32'h104);
        pulse(0);
        acc(1'b0, 32'h110, SZ_WORD, 1);
        expect_msg(TC_READ_SYNC, SZ_WORD, 32'h110);
        bus(1'b1, REG_CTRL, 32'h6);
        pulse(4);
        acc(1'b1, 32'h104, SZ_WORD, 1);
        expect_msg(TC_WRITE_SYNC, SZ_WORD, 32'h104);
        bus(1'b1, REG_CTRL, 32'h0);
        acc(1'b1, 32'h104, SZ_WORD, 1);
        quiet;
        bus(1'b1, REG_CTRL, 32'h2);
        acc(1'b1, 32'h100, SZ_WORD, 1);
        expect_msg(TC_WRITE_SYNC, SZ_WORD, 32'h100);
        for (int i = 1; i <= 256; i++) begin
            acc(1'b1, 32'h100 + 32'(4 * (i % 2)), SZ_WORD, 1);
            expect_msg(TC_WRITE, SZ_WORD, 32'h4);
        end
        acc(1'b1, 32'h100, SZ_WORD, 1);
        expect_msg(TC_WRITE_SYNC, SZ_WORD, 32'h100);
        $display("t_sync done");
    endtask
    task automatic t_watch;
        bus(1'b1, REG_ACTION, 32'hC000_0001);
        acc(1'b1, 32'h120, SZ_HALF, 1);
        expect_msg(TC_WRITE, SZ_HALF, 32'h020);
        expect_msg(TC_WATCH, SZ_HALF, 32'h120);
        bus(1'b1, REG_CTRL, 32'h0);
        pulse(2);
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK(rd[CTRL_TM_DATA], 1'b1)
        pulse(3);
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK(rd[CTRL_TM_DATA], 1'b0)
        $display("t_watch done");
    endtask
    task automatic t_over;
        bus(1'b1, REG_ACTION, 32'hC000_0000);
        bus(1'b1, REG_CTRL, 32'h2);
        stall <= 1'b1;
        acc(1'b1, 32'h140, SZ_WORD, 8);
        stall <= 1'b0;
        repeat (40) @(posedge ref_clk_in);
        acc(1'b1, 32'h100, SZ_WORD, 1);
        repeat (10) @(posedge ref_clk_in);
        while (i_tool.got.size() > 1 && i_tool.got[0][103:98] !== TC_ERROR) void'(i_tool.got.pop_front());
        `CHK(i_tool.got[0][110:98], {2'b00, ECODE_OVERRUN, TC_ERROR})
        `CHK(i_tool.got[1][110:98], {2'b00, 5'h00, TC_WRITE_SYNC})
        i_tool.got.delete();
        bus(1'b1, REG_START0, 32'h200);
        acc(1'b1, 32'h180, SZ_WORD, 1);
        quiet;
        $display("t_over done");
    endtask
    initial begin
        {rst_n_in, hsel, hwr, av, aw, pv, stall, htr, asz, haddr, hwd, aa, ad} = '0;
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        t_regs;
        t_trace;
        t_sync;
        t_watch;
        t_over;
        end_of_test;
    end
endmodule // data_trace_message_unit_test
`default_nettype wire
